// ---- common/scmc_pkg.sv ----
// Package of constants and types for the system clock and mode controller
package scmc_pkg;

  // ==========================================================================
  // Register map and fields
  localparam logic [7:0] SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS     = 8'h00;
  localparam logic [7:0] SCMC_CTRL_OFS     = 8'h04;
  localparam logic [7:0] SCMC_SYSTEM_MODE_CLOCK_SELECT_RESET   = 8'h03;
  localparam logic [7:0] SCMC_CTRL_RESET   = 8'h00;
  localparam logic [7:0] SCMC_SYSTEM_MODE_CLOCK_SELECT_WMASK   = 8'he3;
  localparam logic [7:0] SCMC_CTRL_WMASK   = 8'hb0;
  localparam int         SCMC_HIGH_LOW_CLOCK_SELECT_BIT    = 0;
  localparam int         SCMC_IDLE_ON_HALT_ENABLE_BIT    = 1;
  localparam int         SCMC_HTO_BIT      = 2;
  localparam int         SCMC_LTO_BIT      = 3;
  localparam int         SCMC_CKS_LSB      = 5;
  localparam int         SCMC_IDLE_SYSTEM_CLOCK_ENABLE_BIT   = 7;
  localparam int         SCMC_HIRCS_LSB    = 4;

  // ==========================================================================
  // Codes, timing counts and bus answers
  localparam logic [2:0] SCMC_CKS_DIV64    = 3'h2;
  localparam logic [4:0] SCMC_HTO_WAIT     = 5'h0f;
  localparam logic [1:0] SCMC_LTO_WAIT     = 2'h2;
  localparam logic [1:0] SCMC_RESP_OKAY    = 2'h0;
  localparam logic [1:0] SCMC_RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    SCMC_FAST  = 3'b000,
    SCMC_SLOW  = 3'b001,
    SCMC_SLEEP = 3'b010,
    SCMC_IDLE_CLOCK_OFF_MODE = 3'b011,
    SCMC_IDLE_CLOCK_ON_MODE = 3'b100,
    SCMC_WAKE  = 3'b101
  } scmc_mode_t;

  typedef struct packed {
    logic       high_sel;
    logic [2:0] div_sel;
  } scmc_sel_t;

endpackage

// ---- rtl/scmc_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module scmc_sync
  import scmc_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ==========================================================================
  // Stages; the output follows only when stage two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        sync_out <= s3_reg;
      end
    end
  end

endmodule

// ---- rtl/scmc_divider.sv ----
// System clock source mux and divider, producing glitch-free clock enables
`timescale 1ns/100ps
module scmc_divider
  import scmc_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      ce,
  input  wire logic      high_run,
  input  wire logic      low_tick,
  input  wire scmc_sel_t sel,
  output logic           sys_tick,
  output logic           src_high
);

  scmc_sel_t  cur_reg;
  logic [5:0] cnt_reg;
  logic       tick;
  logic       want_high;

  function automatic logic [5:0] div_mask(input logic [2:0] cks);
    logic [5:0] m;
    m = 6'h3f >> (cks - SCMC_CKS_DIV64);
    return m;
  endfunction

  function automatic logic is_high(input scmc_sel_t s);
    return s.high_sel | (s.div_sel >= SCMC_CKS_DIV64);
  endfunction

  assign want_high = is_high(sel);

  always_comb
  begin
    if (!is_high(cur_reg))
      tick = low_tick;
    else if (cur_reg.high_sel)
      tick = high_run;
    else
      tick = high_run && ((cnt_reg & div_mask(cur_reg.div_sel)) == div_mask(cur_reg.div_sel));
  end

  // ==========================================================================
  // Selection moves only at the end of a whole period; a stopped fast source
  // gives no pulses, so falling back to the slow clock then is also safe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_reg  <= '0;
      cnt_reg  <= 6'h00;
      sys_tick <= 1'b0;
      src_high <= 1'b0;
    end
    else if (ce)
    begin
      sys_tick <= tick;
      cnt_reg  <= high_run ? cnt_reg + 6'h01 : 6'h00;
      if (tick || (is_high(cur_reg) && !high_run))
      begin
        // A fast choice waits on the slow clock until the oscillator is ready
        if (want_high && !high_run)
          cur_reg <= '0;
        else
          cur_reg <= sel;
        cnt_reg  <= 6'h00;
        src_high <= want_high && high_run;
      end
    end
  end

endmodule

// ---- rtl/scmc_top.sv ----
// System clock and operating-mode controller with AXI4-Lite register access
`timescale 1ns/100ps
module scmc_top
  import scmc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  input  wire logic        fast_osc_stable,
  input  wire logic        slow_osc_stable,
  input  wire logic        slow_osc_clk,
  output logic             fast_osc_enable,
  output logic             slow_osc_enable,
  output logic [1:0]       fast_rc_frequency_select,
  output logic             fast_div_available,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             cpu_run,
  output logic [2:0]       mode_state
);

  // ==========================================================================
  // Declarations
  scmc_mode_t  state_reg;
  scmc_mode_t  state_next;
  logic [7:0]  system_mode_clock_select_reg;
  logic [7:0]  ctrl_reg;
  logic        high_ready_reg;
  logic        low_ready_reg;
  logic [4:0]  hto_cnt_reg;
  logic [1:0]  lto_cnt_reg;
  logic        slow_clk_prev_reg;
  logic        fast_stable_s;
  logic        slow_stable_s;
  logic        slow_clk_s;
  logic        low_tick;
  logic        sys_tick;
  logic        src_high;
  logic        uses_high;
  logic        fast_on_next;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane0_reg;
  logic        do_write;
  logic [31:0] rd_word;
  logic        rd_hit;
  scmc_sel_t   sel;

  // ==========================================================================
  // Pin inputs from the oscillators cross into the aclk domain
  scmc_sync u_sync_fast (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (clk_en),
    .async_in (fast_osc_stable),
    .sync_out (fast_stable_s)
  );

  scmc_sync u_sync_slow (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (clk_en),
    .async_in (slow_osc_stable),
    .sync_out (slow_stable_s)
  );

  scmc_sync u_sync_sclk (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (clk_en),
    .async_in (slow_osc_clk),
    .sync_out (slow_clk_s)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      slow_clk_prev_reg <= 1'b0;
    else if (clk_en)
      slow_clk_prev_reg <= slow_clk_s;
  end

  // One pulse per rising edge of the slow oscillator
  assign low_tick = slow_clk_s && !slow_clk_prev_reg;

  // ==========================================================================
  // Clock selection
  assign sel.high_sel = system_mode_clock_select_reg[SCMC_HIGH_LOW_CLOCK_SELECT_BIT];
  assign sel.div_sel  = system_mode_clock_select_reg[SCMC_CKS_LSB +: 3];
  assign uses_high    = sel.high_sel | (sel.div_sel >= SCMC_CKS_DIV64);

  scmc_divider u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (clk_en),
    .high_run (high_ready_reg),
    .low_tick (low_tick),
    .sel      (sel),
    .sys_tick (sys_tick),
    .src_high (src_high)
  );

  // ==========================================================================
  // Operating mode machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SCMC_FAST, SCMC_SLOW:
      begin
        if (halt_req)
        begin
          if (!system_mode_clock_select_reg[SCMC_IDLE_ON_HALT_ENABLE_BIT])
            state_next = SCMC_SLEEP;
          else if (!ctrl_reg[SCMC_IDLE_SYSTEM_CLOCK_ENABLE_BIT])
            state_next = SCMC_IDLE_CLOCK_OFF_MODE;
          else
            state_next = SCMC_IDLE_CLOCK_ON_MODE;
        end
        else
          state_next = uses_high ? SCMC_FAST : SCMC_SLOW;
      end
      SCMC_SLEEP, SCMC_IDLE_CLOCK_OFF_MODE:
      begin
        if (wake_req)
          state_next = uses_high ? SCMC_WAKE : SCMC_SLOW;
      end
      SCMC_IDLE_CLOCK_ON_MODE:
      begin
        if (wake_req)
        begin
          if (!uses_high)
            state_next = SCMC_SLOW;
          else
            state_next = high_ready_reg ? SCMC_FAST : SCMC_WAKE;
        end
      end
      SCMC_WAKE:
      begin
        if (high_ready_reg)
          state_next = SCMC_FAST;
      end
      default:
        state_next = SCMC_FAST;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= SCMC_FAST;
    else if (clk_en)
      state_reg <= state_next;
  end

  // ==========================================================================
  // Fast oscillator enable
  always_comb
  begin
    case (state_next)
      SCMC_FAST:  fast_on_next = 1'b1;
      SCMC_WAKE:  fast_on_next = 1'b1;
      SCMC_SLOW:  fast_on_next = 1'b0;
      SCMC_IDLE_CLOCK_ON_MODE: fast_on_next = src_high;
      SCMC_SLEEP: fast_on_next = 1'b0;
      SCMC_IDLE_CLOCK_OFF_MODE: fast_on_next = 1'b0;
      default:    fast_on_next = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fast_osc_enable    <= 1'b1;
      slow_osc_enable    <= 1'b1;
      fast_div_available <= 1'b0;
    end
    else if (clk_en)
    begin
      fast_osc_enable    <= fast_on_next;
      // The watchdog depends on it, so nothing ever turns it off
      slow_osc_enable    <= 1'b1;
      fast_div_available <= fast_on_next && high_ready_reg;
    end
  end

  // ==========================================================================
  // Ready flags; a fresh start of either oscillator restarts its count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hto_cnt_reg    <= 5'h00;
      high_ready_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!fast_osc_enable || !fast_stable_s)
      begin
        hto_cnt_reg    <= 5'h00;
        high_ready_reg <= 1'b0;
      end
      else if (hto_cnt_reg != SCMC_HTO_WAIT)
        hto_cnt_reg <= hto_cnt_reg + 5'h01;
      else
        high_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lto_cnt_reg   <= 2'h0;
      low_ready_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!slow_stable_s)
      begin
        lto_cnt_reg   <= 2'h0;
        low_ready_reg <= 1'b0;
      end
      else if (lto_cnt_reg != SCMC_LTO_WAIT)
      begin
        if (low_tick)
          lto_cnt_reg <= lto_cnt_reg + 2'h1;
      end
      else
        low_ready_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Clock enables toward the CPU and peripherals
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      cpu_run       <= 1'b0;
      mode_state    <= SCMC_FAST;
    end
    else if (clk_en)
    begin
      cpu_run       <= (state_reg == SCMC_FAST) || (state_reg == SCMC_SLOW);
      cpu_clk_en    <= sys_tick && ((state_reg == SCMC_FAST) || (state_reg == SCMC_SLOW));
      // The system clock keeps peripherals alive in fast, slow and clock-on idle only
      periph_clk_en <= sys_tick && (state_reg != SCMC_SLEEP) && (state_reg != SCMC_IDLE_CLOCK_OFF_MODE)
                       && (state_reg != SCMC_WAKE);
      mode_state    <= state_reg;
    end
  end

  assign fast_rc_frequency_select = ctrl_reg[SCMC_HIRCS_LSB +: 2];

  // ==========================================================================
  // AXI4-Lite write path; address and data may arrive in either order
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 8'h00;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SCMC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata[7:0];
        w_lane0_reg  <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ((aw_addr_reg == SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS) || (aw_addr_reg == SCMC_CTRL_OFS))
          s_axi_bresp <= SCMC_RESP_OKAY;
        else
          s_axi_bresp <= SCMC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Registers; read-only flags and empty bit positions never store a write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      system_mode_clock_select_reg <= SCMC_SYSTEM_MODE_CLOCK_SELECT_RESET;
      ctrl_reg <= SCMC_CTRL_RESET;
    end
    else if (clk_en && do_write && w_lane0_reg)
    begin
      if (aw_addr_reg == SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS)
        system_mode_clock_select_reg <= w_data_reg & SCMC_SYSTEM_MODE_CLOCK_SELECT_WMASK;
      if (aw_addr_reg == SCMC_CTRL_OFS)
        ctrl_reg <= w_data_reg & SCMC_CTRL_WMASK;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS)
    begin
      rd_word[7:0]          = system_mode_clock_select_reg & SCMC_SYSTEM_MODE_CLOCK_SELECT_WMASK;
      rd_word[SCMC_HTO_BIT] = high_ready_reg;
      rd_word[SCMC_LTO_BIT] = low_ready_reg;
    end
    else if (s_axi_araddr == SCMC_CTRL_OFS)
      rd_word[7:0] = ctrl_reg & SCMC_CTRL_WMASK;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SCMC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? SCMC_RESP_OKAY : SCMC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- verification/scmc_top_asserts.sv ----
// Concurrent checks on the clock and mode controller outputs
`timescale 1ns/100ps
module scmc_top_asserts
  import scmc_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       clk_en,
  input wire logic       s_axi_wvalid,
  input wire logic       halt_req,
  input wire logic       wake_req,
  input wire logic       fast_osc_enable,
  input wire logic       slow_osc_enable,
  input wire logic [1:0] fast_rc_frequency_select,
  input wire logic       fast_div_available,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       cpu_run,
  input wire logic [2:0] mode_state
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Cycles the fast oscillator has been enabled, saturating
  logic [4:0] osc_on_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !fast_osc_enable)
      osc_on_reg <= 5'h00;
    else if (osc_on_reg != 5'h1f)
      osc_on_reg <= osc_on_reg + 5'h01;
  end
  // ==========================================================================
  // Mode steps; a wake just seen may not yet show on the mode output
  sequence halt_taken_s;
    clk_en && halt_req && cpu_run && mode_state inside {SCMC_FAST, SCMC_SLOW}
      && $stable(mode_state);
  endsequence
  sequence wake_taken_s;
    wake_req && mode_state inside {SCMC_SLEEP, SCMC_IDLE_CLOCK_OFF_MODE, SCMC_IDLE_CLOCK_ON_MODE} && $stable(mode_state);
  endsequence
  sequence parked_s;
    mode_state inside {SCMC_SLEEP, SCMC_IDLE_CLOCK_OFF_MODE, SCMC_IDLE_CLOCK_ON_MODE} && !$past(wake_req)
      && !$past(wake_req, 2);
  endsequence
  halt_to_idle_a: assert property (halt_taken_s |-> ##2 mode_state inside {SCMC_SLEEP, SCMC_IDLE_CLOCK_OFF_MODE, SCMC_IDLE_CLOCK_ON_MODE})
    else $error("halt did not park the core");
  wake_exit_a: assert property (wake_taken_s |-> ##2 mode_state inside {SCMC_WAKE, SCMC_FAST, SCMC_SLOW})
    else $error("wake did not leave the idle state");
  cpu_stop_a: assert property (parked_s |-> !cpu_clk_en && !cpu_run)
    else $error("cpu clocked while parked");
  idle_periph_a: assert property (parked_s ##0 (mode_state != SCMC_IDLE_CLOCK_ON_MODE) |-> !periph_clk_en && !fast_osc_enable)
    else $error("clock running in sleep or clock-off idle");
  idle_clock_on_mode_periph_a: assert property (mode_state == SCMC_IDLE_CLOCK_ON_MODE |-> ##[0:300] periph_clk_en)
    else $error("no peripheral clock in clock-on idle");
  slow_entry_a: assert property ($rose(mode_state == SCMC_SLOW) |-> !fast_osc_enable ##2 !fast_div_available)
    else $error("fast oscillator left on in slow mode");
  slow_osc_on_a: assert property (slow_osc_enable)
    else $error("slow oscillator disabled");
  fast_ready_a: assert property ($rose(fast_div_available) |-> osc_on_reg >= 5'h0f)
    else $error("fast clock usable before start-up wait");
  freq_write_a: assert property ($changed(fast_rc_frequency_select) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("frequency select changed without a write");
endmodule

// ---- verification/test_scmc_top.sv ----
// Self-checking bench for the clock and mode controller
`timescale 1ns/100ps
module test_scmc_top
  import scmc_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        halt_req = 1'b0;
  logic        wake_req = 1'b0;
  logic        clk_en = 1'b1;
  logic        fast_osc_stable = 1'b0;
  logic        slow_osc_stable = 1'b0;
  logic        fast_ok = 1'b0;
  logic        slow_ok = 1'b0;
  logic [3:0]  slow_div_reg = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fast_rc_frequency_select;
  logic [31:0] s_axi_rdata;
  logic        fast_osc_enable, slow_osc_enable, fast_div_available;
  logic        cpu_clk_en, periph_clk_en, cpu_run;
  logic [2:0]  mode_state;
  int          bad_count = 0;
  int          checks_done = 0;
  wire logic   slow_osc_clk = slow_div_reg[3];

  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // Oscillators report stable one cycle after being enabled, once allowed
  always @(posedge aclk)
  begin
    fast_osc_stable <= fast_osc_enable & fast_ok;
    slow_osc_stable <= slow_ok;
    slow_div_reg <= slow_div_reg + 4'h1;
  end

  scmc_top u_dut
  (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .halt_req(halt_req), .wake_req(wake_req),
    .fast_osc_stable(fast_osc_stable), .slow_osc_stable(slow_osc_stable),
    .slow_osc_clk(slow_osc_clk), .fast_osc_enable(fast_osc_enable),
    .slow_osc_enable(slow_osc_enable), .fast_rc_frequency_select(fast_rc_frequency_select),
    .fast_div_available(fast_div_available), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .cpu_run(cpu_run), .mode_state(mode_state)
  );

  // ==========================================================================
  // Checks and expectations
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  function automatic int sys_div(input logic hl, input logic [2:0] c);
    return hl ? 1 : (256 >> c);
  endfunction
  function automatic logic [2:0] halt_mode(input logic idl, input logic fsy);
    return !idl ? SCMC_SLEEP : (fsy ? SCMC_IDLE_CLOCK_ON_MODE : SCMC_IDLE_CLOCK_OFF_MODE);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Bus cycles; each starts one edge after the last to avoid double drives
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", {30'h0, SCMC_RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(what, exp, d);
    chk("rresp", {30'h0, SCMC_RESP_OKAY}, {30'h0, r});
  endtask
  task automatic pulse(input logic wake);
    @(posedge aclk);
    if (wake)
      wake_req <= 1'b1;
    else
      halt_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    halt_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wait_until(input logic [2:0] m, input logic need_ready);
    int n;
    n = 0;
    while ((mode_state !== m || (need_ready && fast_div_available !== 1'b1)) && n < 600)
    begin
      @(posedge aclk);
      n++;
    end
    chk("mode reached", {29'h0, m}, {29'h0, mode_state});
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin : main_seq
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    int          cnt;
    void'($urandom(32'h26e4));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("system_mode_clock_select reset", SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, 32'h03);
    rd_chk("ctrl reset", SCMC_CTRL_OFS, 32'h00);
    $display("test reset values done");
    // A halt while frozen must leave every state untouched
    clk_en <= 1'b0;
    pulse(1'b0);
    clk_en <= 1'b1;
    chk("frozen mode", {29'h0, SCMC_FAST}, {29'h0, mode_state});
    $display("test clock enable done");
    // Oscillators still unstable, so both ready flags must stay clear
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'hffff_ffff : $urandom;
      wr_ok(SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, d);
      rd_chk("system_mode_clock_select rw", SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, {24'h0, d[7:0] & 8'he3});
      d = (i == 0) ? 32'hffff_ffff : $urandom;
      wr_ok(SCMC_CTRL_OFS, d);
      rd_chk("ctrl rw", SCMC_CTRL_OFS, {24'h0, d[7:0] & 8'hb0});
      chk("freq sel", {30'h0, d[5:4]}, {30'h0, fast_rc_frequency_select});
    end
    v = {6'($urandom_range(63, 2)), 2'b00};
    axi_wr(v, 32'hffff_ffff, r);
    chk("unmapped bresp", {30'h0, SCMC_RESP_SLVERR}, {30'h0, r});
    axi_rd(v, d, r);
    chk("unmapped rresp", {30'h0, SCMC_RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    $display("test register access done");
    wr_ok(SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, 32'h01);
    fast_ok <= 1'b1;
    slow_ok <= 1'b1;
    repeat (100) @(posedge aclk);
    rd_chk("ready flags", SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, 32'h0d);
    $display("test ready flags done");
    // Every select code, then the undivided fast clock last
    for (int c = 0; c < 9; c++)
    begin
      v = (c == 8) ? 8'h01 : {c[2:0], 5'h00};
      wr_ok(SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, {24'h0, v});
      if (c < 2)
      begin
        wait_until(SCMC_SLOW, 1'b0);
        repeat (8) @(posedge aclk);
        chk("fast osc off", 32'h0, {31'h0, fast_osc_enable});
        chk("fast div off", 32'h0, {31'h0, fast_div_available});
      end
      else
      begin
        wait_until(SCMC_FAST, 1'b1);
        repeat (200) @(posedge aclk);
        cnt = 0;
        repeat (256)
        begin
          @(posedge aclk);
          cnt += int'(cpu_clk_en === 1'b1);
        end
        d = 256 / sys_div(v[0], v[7:5]);
        chk("clock pulses", d, (cnt + 1 >= d && cnt <= d + 1) ? d : cnt);
      end
    end
    $display("test clock select done");
    for (int k = 0; k < 4; k++)
    begin
      wr_ok(SCMC_CTRL_OFS, {24'h0, k[0], 1'b0, 2'($urandom), 4'h0});
      wr_ok(SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, {24'h0, 6'h00, k[1], 1'b1});
      wait_until(SCMC_FAST, 1'b1);
      pulse(1'b0);
      chk("halt mode", {29'h0, halt_mode(k[1], k[0])}, {29'h0, mode_state});
      chk("fast osc parked", {31'h0, k == 3}, {31'h0, fast_osc_enable});
      chk("slow osc", 32'h1, {31'h0, slow_osc_enable});
      axi_rd(SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, d, r);
      chk("fast flag parked", {31'h0, k == 3}, {31'h0, d[2]});
      pulse(1'b0);
      chk("halt ignored", {29'h0, halt_mode(k[1], k[0])}, {29'h0, mode_state});
      pulse(1'b1);
      wait_until(SCMC_FAST, 1'b0);
      axi_rd(SCMC_SYSTEM_MODE_CLOCK_SELECT_OFS, d, r);
      chk("fast flag on wake", 32'h1, {31'h0, d[2]});
    end
    $display("test halt and wake done");
    print_verdict();
  end

  initial
  begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule

bind scmc_top scmc_top_asserts u_asserts
(
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_wvalid(s_axi_wvalid), .halt_req(halt_req),
  .wake_req(wake_req), .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
  .fast_rc_frequency_select(fast_rc_frequency_select), .fast_div_available(fast_div_available),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_run(cpu_run),
  .mode_state(mode_state)
);
